// [rtl/phy_irq_pkg.sv]
package phy_irq_pkg;

	// Register indices as printed; the byte address is four times the index.
	localparam int unsigned IDX_CABLE = 28;
	localparam int unsigned IDX_FLAGS = 29;
	localparam int unsigned IDX_MASK = 30;
	localparam int unsigned ADDR_W = 12;
	localparam logic [11:0] ADDR_CABLE = 12'(IDX_CABLE * 4);
	localparam logic [11:0] ADDR_FLAGS = 12'(IDX_FLAGS * 4);
	localparam logic [11:0] ADDR_MASK = 12'(IDX_MASK * 4);

	// Field layout of the cable length report register.
	localparam int unsigned CODE_MSB = 15;
	localparam int unsigned CODE_LSB = 12;
	localparam int unsigned RESV_MSB = 11;
	localparam logic [3:0] CODE_RESET = 4'h0;
	localparam logic [11:0] RESV_RESET = 12'h800;

	// Interrupt source flag positions, shared by the mask register.
	localparam int unsigned FLAG_HI = 9;
	localparam int unsigned FLAG_LO = 1;
	localparam int unsigned BIT_LINK_UP = 9;
	localparam int unsigned BIT_WAKE = 8;
	localparam int unsigned BIT_ENERGY = 7;
	localparam int unsigned BIT_AN_DONE = 6;
	localparam int unsigned BIT_RFAULT = 5;
	localparam int unsigned BIT_LINK_DOWN = 4;
	localparam int unsigned BIT_ACK = 3;
	localparam int unsigned BIT_PDF = 2;
	localparam int unsigned BIT_PAGE = 1;
	localparam logic [9:1] FLAGS_RESET = 9'h000;
	localparam logic [9:1] MASK_RESET = 9'h000;

	// Positions inside the synchronised input bundle.
	localparam int unsigned SYNC_W = 14;
	localparam int unsigned S_LINK = 0;
	localparam int unsigned S_WAKE = 1;
	localparam int unsigned S_ENERGY = 2;
	localparam int unsigned S_AN_DONE = 3;
	localparam int unsigned S_RFAULT = 4;
	localparam int unsigned S_ACK = 5;
	localparam int unsigned S_PDF = 6;
	localparam int unsigned S_PAGE = 7;
	localparam int unsigned S_SPEED = 8;
	localparam int unsigned S_CFAULT = 9;
	localparam int unsigned S_CODE_LO = 10;
	localparam int unsigned S_CODE_HI = 13;
	localparam int unsigned EVT_W = 8;

	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage

// [rtl/bit_sync.sv]
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for a bundle of independent levels.
module bit_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule

`default_nettype wire

// [rtl/phy_irq_flags_cable_length.sv]
// Function
// - cable length register at index 28, 16 bits
// - read-only code in bits 15:12, resets zero
// - code valid only for faultless 100BASE-TX link
// - no cable length reported at 10 Mb/s
// - flag register at index 29, read-only
// - enabled flags latch high, reset to zero
// - reading flag register clears reported flags
// - each source gated by matching mask bit
// - bit 9 latches on link up
// - bit 8 latches on wake event
// - bit 7 latches on energy detected
// - bit 6 latches on auto-negotiation done
// - bit 5 latches on remote fault
// - bit 4 latches on link down
// - bit 3 latches on partner acknowledge
// - bit 2 latches on parallel detection fault
// - bit 1 latches on page received
// - mask one enables, zero suppresses, resets zero
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module phy_irq_flags_cable_length (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic link_status_i,
	input wire logic wake_event_i,
	input wire logic energy_detected_i,
	input wire logic autoneg_done_i,
	input wire logic remote_fault_i,
	input wire logic partner_ack_i,
	input wire logic parallel_detect_fault_i,
	input wire logic page_received_i,
	input wire logic link_speed_100_i,
	input wire logic cable_fault_i,
	input wire logic [3:0] cable_length_code_i,
	output logic phy_irq_o
);

	logic [13:0] async_w;
	logic [13:0] sync_w;
	logic [7:0] evt_d_r;
	logic [3:0] code_d_r;
	logic [3:0] cable_code_r;
	logic [11:0] resv_r;
	logic [9:1] flags_r;
	logic [9:1] flags_nxt;
	logic [9:1] mask_r;
	logic [9:1] events_w;
	logic [9:1] set_w;
	logic [9:1] clr_bits_w;
	logic code_valid_w;
	logic access_w;
	logic first_w;
	logic done_w;
	logic clr_w;
	logic [31:0] rdata_w;
	logic hit_w;
	logic [15:0] mask_merge_w;
	logic [15:0] resv_merge_w;

	// Word match on the byte address, ignoring the byte offset.
	function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] reg_addr);
		return a[11:2] == reg_addr[11:2];
	endfunction

	// Merges a write into a 16-bit register under the two low byte strobes.
	function automatic logic [15:0] strb_merge(input logic [15:0] old_v,
			input logic [15:0] new_v, input logic [1:0] strb);
		logic [15:0] res;
		res = old_v;
		if (strb[0]) begin
			res[7:0] = new_v[7:0];
		end
		if (strb[1]) begin
			res[15:8] = new_v[15:8];
		end
		return res;
	endfunction

	// Every status input comes from the PHY core and is synchronised first.
	assign async_w = {cable_length_code_i, cable_fault_i, link_speed_100_i,
		page_received_i, parallel_detect_fault_i, partner_ack_i, remote_fault_i,
		autoneg_done_i, energy_detected_i, wake_event_i, link_status_i};

	bit_sync #(
		.WIDTH(phy_irq_pkg::SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.async_i(async_w),
		.sync_o(sync_w)
	);

	// Previous synchronised levels, used for edge detection and code stability.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			evt_d_r <= 8'h00;
			code_d_r <= 4'h0;
		end else begin
			evt_d_r <= sync_w[phy_irq_pkg::EVT_W-1:0];
			code_d_r <= sync_w[phy_irq_pkg::S_CODE_HI:phy_irq_pkg::S_CODE_LO];
		end
	end

	// The estimate only means something on an up, faultless 100 Mb/s link.
	assign code_valid_w = sync_w[phy_irq_pkg::S_LINK] & sync_w[phy_irq_pkg::S_SPEED] &
		~sync_w[phy_irq_pkg::S_CFAULT];

	// The code is taken only once it has been steady for a cycle, so that a
	// multi-bit change passing the synchroniser is never seen half done.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cable_code_r <= phy_irq_pkg::CODE_RESET;
		end else if (!code_valid_w) begin
			cable_code_r <= phy_irq_pkg::CODE_RESET;
		end else if (sync_w[phy_irq_pkg::S_CODE_HI:phy_irq_pkg::S_CODE_LO] == code_d_r) begin
			cable_code_r <= code_d_r;
		end
	end

	// Edge detection of each source: rising edges, and the falling link edge.
	always_comb begin
		events_w = 9'h000;
		events_w[phy_irq_pkg::BIT_LINK_UP] = sync_w[phy_irq_pkg::S_LINK] &
			~evt_d_r[phy_irq_pkg::S_LINK];
		events_w[phy_irq_pkg::BIT_WAKE] = sync_w[phy_irq_pkg::S_WAKE] &
			~evt_d_r[phy_irq_pkg::S_WAKE];
		events_w[phy_irq_pkg::BIT_ENERGY] = sync_w[phy_irq_pkg::S_ENERGY] &
			~evt_d_r[phy_irq_pkg::S_ENERGY];
		events_w[phy_irq_pkg::BIT_AN_DONE] = sync_w[phy_irq_pkg::S_AN_DONE] &
			~evt_d_r[phy_irq_pkg::S_AN_DONE];
		events_w[phy_irq_pkg::BIT_RFAULT] = sync_w[phy_irq_pkg::S_RFAULT] &
			~evt_d_r[phy_irq_pkg::S_RFAULT];
		events_w[phy_irq_pkg::BIT_LINK_DOWN] = ~sync_w[phy_irq_pkg::S_LINK] &
			evt_d_r[phy_irq_pkg::S_LINK];
		events_w[phy_irq_pkg::BIT_ACK] = sync_w[phy_irq_pkg::S_ACK] &
			~evt_d_r[phy_irq_pkg::S_ACK];
		events_w[phy_irq_pkg::BIT_PDF] = sync_w[phy_irq_pkg::S_PDF] &
			~evt_d_r[phy_irq_pkg::S_PDF];
		events_w[phy_irq_pkg::BIT_PAGE] = sync_w[phy_irq_pkg::S_PAGE] &
			~evt_d_r[phy_irq_pkg::S_PAGE];
	end

	// A source can latch only while its mask bit is one.
	assign set_w = events_w & mask_r;

	// Write data merged under the byte strobes, ahead of the register updates.
	assign mask_merge_w = strb_merge({6'h00, mask_r, 1'b0}, pwdata_i[15:0], pstrb_i[1:0]);
	assign resv_merge_w = strb_merge({4'h0, resv_r}, pwdata_i[15:0], pstrb_i[1:0]);

	// Bus phases: one wait cycle, then the completing access cycle.
	assign access_w = psel_i & penable_i;
	assign first_w = access_w & ~pready_o;
	assign done_w = access_w & pready_o;
	assign hit_w = addr_hit(paddr_i, phy_irq_pkg::ADDR_CABLE) |
		addr_hit(paddr_i, phy_irq_pkg::ADDR_FLAGS) | addr_hit(paddr_i, phy_irq_pkg::ADDR_MASK);

	// A completed read of the flag register clears only what it reported.
	assign clr_w = done_w & ~pwrite_i & addr_hit(paddr_i, phy_irq_pkg::ADDR_FLAGS);
	assign clr_bits_w = clr_w ? prdata_o[phy_irq_pkg::FLAG_HI:phy_irq_pkg::FLAG_LO] : 9'h000;

	// New events are merged after the clear, so the set wins.
	assign flags_nxt = (flags_r & ~clr_bits_w) | set_w;

	// Sticky interrupt source flags.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			flags_r <= phy_irq_pkg::FLAGS_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Read multiplexer; unmapped bits and reserved flag and mask bits read as zero.
	always_comb begin
		rdata_w = phy_irq_pkg::RDATA_ZERO;
		if (addr_hit(paddr_i, phy_irq_pkg::ADDR_CABLE)) begin
			rdata_w[phy_irq_pkg::CODE_MSB:phy_irq_pkg::CODE_LSB] = cable_code_r;
			rdata_w[phy_irq_pkg::RESV_MSB:0] = resv_r;
		end else if (addr_hit(paddr_i, phy_irq_pkg::ADDR_FLAGS)) begin
			rdata_w[phy_irq_pkg::FLAG_HI:phy_irq_pkg::FLAG_LO] = flags_r;
		end else if (addr_hit(paddr_i, phy_irq_pkg::ADDR_MASK)) begin
			rdata_w[phy_irq_pkg::FLAG_HI:phy_irq_pkg::FLAG_LO] = mask_r;
		end
	end

	// Bus answer: ready, error and read data, all registered.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= phy_irq_pkg::RDATA_ZERO;
		end else begin
			pready_o <= first_w;
			pslverr_o <= first_w & ~hit_w;
			if (first_w && !pwrite_i) begin
				prdata_o <= rdata_w;
			end else if (done_w) begin
				prdata_o <= phy_irq_pkg::RDATA_ZERO;
			end
		end
	end

	// Mask register; writes take effect at the completing edge.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			mask_r <= phy_irq_pkg::MASK_RESET;
		end else if (done_w && pwrite_i && addr_hit(paddr_i, phy_irq_pkg::ADDR_MASK)) begin
			mask_r <= mask_merge_w[phy_irq_pkg::FLAG_HI:phy_irq_pkg::FLAG_LO];
		end
	end

	// Reserved low bits of the cable register keep what software writes.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			resv_r <= phy_irq_pkg::RESV_RESET;
		end else if (done_w && pwrite_i && addr_hit(paddr_i, phy_irq_pkg::ADDR_CABLE)) begin
			resv_r <= resv_merge_w[phy_irq_pkg::RESV_MSB:0];
		end
	end

	// Interrupt output from enabled pending flags.
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			phy_irq_o <= 1'b0;
		end else begin
			phy_irq_o <= |(flags_r & mask_r);
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	a_cable_upper_zero: assert property (
		done_w && !pwrite_i && addr_hit(paddr_i, phy_irq_pkg::ADDR_CABLE)
		|-> prdata_o[31:16] == 16'h0000)
		else $error("cable register read shows bits above 16");

	a_cable_code_read: assert property (
		first_w && !pwrite_i && addr_hit(paddr_i, phy_irq_pkg::ADDR_CABLE)
		|=> prdata_o[15:12] == $past(cable_code_r))
		else $error("cable code not returned in bits 15:12");

	a_code_fault_zero: assert property (
		$past(sync_w[phy_irq_pkg::S_CFAULT]) |-> cable_code_r == 4'h0)
		else $error("cable code reported with cable fault");

	a_code_slow_zero: assert property (
		!sync_w[phy_irq_pkg::S_SPEED] ##1 !sync_w[phy_irq_pkg::S_SPEED]
		|-> cable_code_r == 4'h0)
		else $error("cable code reported at 10 Mb/s");

	a_flags_ro_write: assert property (
		done_w && pwrite_i && addr_hit(paddr_i, phy_irq_pkg::ADDR_FLAGS)
		|=> flags_r == ($past(flags_r) | $past(set_w)))
		else $error("write changed flag register");

	a_flags_sticky: assert property (
		!clr_w |=> (flags_r & $past(flags_r)) == $past(flags_r))
		else $error("flag dropped without a clearing read");

	a_read_clears: assert property (
		clr_w && set_w == 9'h000 |=> (flags_r & $past(prdata_o[9:1])) == 9'h000)
		else $error("reported flag survived clearing read");

	a_mask_gates_set: assert property (
		((flags_r & ~$past(flags_r)) & ~$past(mask_r)) == 9'h000)
		else $error("masked source latched a flag");

	a_link_up_latch: assert property (
		events_w[phy_irq_pkg::BIT_LINK_UP] && mask_r[phy_irq_pkg::BIT_LINK_UP]
		|=> flags_r[phy_irq_pkg::BIT_LINK_UP] ##1 flags_r[phy_irq_pkg::BIT_LINK_UP] || $past(clr_w))
		else $error("link up event not latched");

	a_link_down_latch: assert property (
		$fell(sync_w[phy_irq_pkg::S_LINK]) && mask_r[phy_irq_pkg::BIT_LINK_DOWN]
		|=> flags_r[phy_irq_pkg::BIT_LINK_DOWN])
		else $error("link down event not latched");

	a_irq_follows: assert property (
		##1 phy_irq_o == (|($past(flags_r) & $past(mask_r))))
		else $error("interrupt output disagrees with flags and mask");

	a_set_beats_clear: assert property (
		clr_w |=> (flags_r & $past(set_w)) == $past(set_w))
		else $error("event lost during clearing read");

	// Bus answer: one wait cycle, a one-cycle ready, and data only while ready.
	a_ready_one_wait: assert property (
		first_w |=> pready_o ##1 !pready_o)
		else $error("bus answer not given after one wait cycle");

	a_rdata_idle_zero: assert property (
		!pready_o |-> prdata_o == phy_irq_pkg::RDATA_ZERO)
		else $error("read data shown outside the answer cycle");

	a_unmapped_error: assert property (
		first_w && !hit_w |=> pslverr_o && prdata_o == phy_irq_pkg::RDATA_ZERO)
		else $error("unmapped access not answered with an error");

	a_flag_reserved_bits: assert property (
		done_w && !pwrite_i && addr_hit(paddr_i, phy_irq_pkg::ADDR_FLAGS)
		|-> prdata_o[15:10] == 6'h00 && !prdata_o[0])
		else $error("reserved flag bits read nonzero");

	a_mask_write: assert property (
		done_w && pwrite_i && addr_hit(paddr_i, phy_irq_pkg::ADDR_MASK) && pstrb_i[1:0] == 2'b11
		|=> mask_r == $past(pwdata_i[9:1]))
		else $error("mask register did not take a full write");

	a_code_needs_link: assert property (
		!sync_w[phy_irq_pkg::S_LINK] |=> cable_code_r == 4'h0)
		else $error("cable code reported without link");

	c_clear_read: cover property (clr_w && prdata_o[9:1] != 9'h000);
	c_set_and_clear: cover property (clr_w && set_w != 9'h000);
	c_irq_rise: cover property ($rose(phy_irq_o));
	c_code_valid: cover property (cable_code_r != 4'h0);
	c_masked_event: cover property ((events_w & ~mask_r) != 9'h000);

endmodule

`default_nettype wire

// [tb/test_phy_irq_flags_cable_length.sv]
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module test_phy_irq_flags_cable_length;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic phy_irq_o;
	logic link = 1'b0;
	logic speed = 1'b0;
	logic cfault = 1'b0;
	logic [3:0] code = 4'h0;
	logic [8:1] ev = 8'h00;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	logic [31:0] rdat;
	logic rerr;
	logic [3:0] strb_sel = 4'hf;

	phy_irq_flags_cable_length u_dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(pstrb), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.link_status_i(link), .wake_event_i(ev[8]), .energy_detected_i(ev[7]),
		.autoneg_done_i(ev[6]), .remote_fault_i(ev[5]), .partner_ack_i(ev[3]),
		.parallel_detect_fault_i(ev[2]), .page_received_i(ev[1]),
		.link_speed_100_i(speed), .cable_fault_i(cfault), .cable_length_code_i(code),
		.phy_irq_o(phy_irq_o));

	// The clock toggles every half period of 10 ns.
	always #10 clk_i = ~clk_i;

	// Prints the counts and the verdict, then stops the run.
	task automatic close_out();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// A hung handshake is cut short here and counted as a mismatch.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			close_out();
		end
	end

	// One APB transfer: setup, then access until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= strb_sel;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rdat = prdata_o;
		rerr = pslverr_o;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reads one register and compares data and error response.
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rdat, exp)
		`CHK(rerr, 1'b0)
	endtask

	// Writes one register and expects no error response.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		`CHK(rerr, 1'b0)
	endtask

	// Makes one source event; bit 9 raises the link and bit 4 drops it.
	task automatic fire(input int b);
		@(posedge clk_i);
		if (b == 9) begin
			link <= 1'b1;
		end else if (b == 4) begin
			link <= 1'b0;
		end else begin
			ev[b] <= 1'b1;
		end
		repeat (6) @(posedge clk_i);
		ev <= 8'h00;
	endtask

	// Main sequence of register accesses and source events.
	initial begin
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(phy_irq_pkg::ADDR_CABLE, 32'h0000_0800);
		rd(phy_irq_pkg::ADDR_FLAGS, 32'h0000_0000);
		rd(phy_irq_pkg::ADDR_MASK, 32'h0000_0000);
		`CHK(phy_irq_o, 1'b0)
		wr(phy_irq_pkg::ADDR_MASK, 32'h0000_03fe);
		rd(phy_irq_pkg::ADDR_MASK, 32'h0000_03fe);
		// Each source in turn latches its own bit and raises the interrupt.
		for (int b = 9; b >= 1; b--) begin
			fire(b);
			`CHK(phy_irq_o, 1'b1)
			rd(phy_irq_pkg::ADDR_FLAGS, 32'h1 << b);
			rd(phy_irq_pkg::ADDR_FLAGS, 32'h0000_0000);
			repeat (2) @(posedge clk_i);
			`CHK(phy_irq_o, 1'b0)
		end
		// A masked wake event is dropped and not latched once unmasked.
		wr(phy_irq_pkg::ADDR_MASK, 32'h0000_02fe);
		fire(8);
		`CHK(phy_irq_o, 1'b0)
		rd(phy_irq_pkg::ADDR_FLAGS, 32'h0000_0000);
		wr(phy_irq_pkg::ADDR_MASK, 32'h0000_03fe);
		rd(phy_irq_pkg::ADDR_FLAGS, 32'h0000_0000);
		// A write to the flag register leaves the latched flags alone.
		fire(6);
		wr(phy_irq_pkg::ADDR_FLAGS, 32'h0000_0000);
		rd(phy_irq_pkg::ADDR_FLAGS, 32'h0000_0040);
		// Only the low byte lane of the mask takes a write with one strobe.
		strb_sel = 4'h1;
		wr(phy_irq_pkg::ADDR_MASK, 32'h0000_0000);
		strb_sel = 4'hf;
		rd(phy_irq_pkg::ADDR_MASK, 32'h0000_0300);
		wr(phy_irq_pkg::ADDR_MASK, 32'h0000_03fe);
		// The cable code shows only on a faultless 100 Mb/s link.
		code <= 4'ha;
		speed <= 1'b1;
		link <= 1'b1;
		repeat (10) @(posedge clk_i);
		`CHK(phy_irq_o, 1'b1)
		rd(phy_irq_pkg::ADDR_CABLE, 32'h0000_a800);
		cfault <= 1'b1;
		repeat (10) @(posedge clk_i);
		rd(phy_irq_pkg::ADDR_CABLE, 32'h0000_0800);
		cfault <= 1'b0;
		speed <= 1'b0;
		repeat (10) @(posedge clk_i);
		rd(phy_irq_pkg::ADDR_CABLE, 32'h0000_0800);
		speed <= 1'b1;
		wr(phy_irq_pkg::ADDR_CABLE, 32'h0000_5800);
		repeat (10) @(posedge clk_i);
		rd(phy_irq_pkg::ADDR_CABLE, 32'h0000_a800);
		// An unmapped address answers with an error and zero data.
		apb(1'b0, 12'h040, 32'h0000_0000);
		`CHK(rerr, 1'b1)
		`CHK(rdat, 32'h0000_0000)
		close_out();
	end
endmodule

`default_nettype wire
